//--- sts_defines.svh
// Register offsets, command codes, field positions and sizes of the timestamp capture block.
`ifndef STS_DEFINES_SVH
`define STS_DEFINES_SVH
`define STS_CMD_OFS      16'hb798
`define STS_DLO_OFS      16'hb7a0
`define STS_DHI_OFS      16'hb7a4
`define STS_STAT_OFS     16'hb7a8
`define STS_ZERO_CODE    32'h0000_0000
`define STS_OFF_CODE     32'h0000_000a
`define STS_START_CODE   32'h0000_000b
`define STS_FREE_CODE    32'h0000_000c
`define STS_CNT_W        48
`define STS_PTR_W        16
`define STS_FILL_W       17
`define STS_DEPTH        17'h1_0000
`define STS_STAT_FULL    31
`define STS_STAT_EMPTY   30
`define STS_GATE_PH_LAST 3'h7
`define STS_BE_ALL       4'hf
`endif

//--- sts_pkg.sv
// Types shared by the timestamp capture block.
package sts_pkg;
    typedef logic [47:0] sts_stamp_t;
    typedef enum logic [1:0] {sts_off, sts_free, sts_start} sts_mode_t;
endpackage

//--- sts_fifo_if.sv
// Write and read ports between the capture logic and the timestamp memory.
`timescale 1ns/1ns
interface sts_fifo_if;
    logic               wr_en;
    logic [15:0]        wr_addr;
    sts_pkg::sts_stamp_t wr_data;
    logic [15:0]        rd_addr;
    sts_pkg::sts_stamp_t rd_data;
    modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

//--- sts_stamp_mem.sv
// Timestamp memory with registered read data.
`timescale 1ns/1ns
`include "sts_defines.svh"
module sts_stamp_mem (
    // Clock.
    input wire logic   mclk,
    // Memory ports.
    sts_fifo_if.mem    f
);
    sts_pkg::sts_stamp_t ram [0:(1 << `STS_PTR_W) - 1];

    always_ff @(posedge mclk) begin
        if (f.wr_en) begin
            ram[f.wr_addr] <= f.wr_data;
        end
        f.rd_data <= ram[f.rd_addr];
    end
endmodule // sts_stamp_mem

//--- sts_gate_align.sv
// Finds the start of each gate segment and its end on an eight-sample boundary.
`timescale 1ns/1ns
`include "sts_defines.svh"
module sts_gate_align (
    // Clock and reset.
    input  wire logic mclk,
    input  wire logic rst,
    // Gate condition.
    input  wire logic gate_on,
    input  wire logic gate_level,
    // Segment events.
    output logic      seg_start,
    output logic      seg_end
);
    logic       prev_q;
    logic       in_seg_q;
    logic       pend_q;
    logic [2:0] phase_q;
    logic       rise;
    logic       fin;

    assign rise = gate_on & gate_level & ~prev_q & ~in_seg_q;
    assign fin  = in_seg_q & (phase_q == `STS_GATE_PH_LAST) & (pend_q | ~gate_level); // R16

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= gate_level;
        end
    end

    // The segment phase counts samples so the end lands on an aligned boundary.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            in_seg_q <= 1'b0;
            pend_q   <= 1'b0;
            phase_q  <= 3'h0;
        end else if (rise) begin
            in_seg_q <= 1'b1;
            pend_q   <= 1'b0;
            phase_q  <= 3'h1;
        end else if (fin || !gate_on) begin
            in_seg_q <= 1'b0;
            pend_q   <= 1'b0;
            phase_q  <= 3'h0;
        end else if (in_seg_q) begin
            pend_q   <= pend_q | ~gate_level; // R16
            phase_q  <= phase_q + 3'h1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            seg_start <= 1'b0;
            seg_end   <= 1'b0;
        end else begin
            seg_start <= rise; // R3
            seg_end   <= fin & gate_on; // R3
        end
    end

    property p_end_bound;
        @(posedge mclk) disable iff (rst || !gate_on)
        (gate_on && in_seg_q && !gate_level) |-> ##[1:8] seg_end;
    endproperty
    a_end_bound: assert property (p_end_bound) else $error("Gate end not seen within eight samples."); // R16

    property p_end_aligned;
        @(posedge mclk) disable iff (rst)
        seg_end |-> $past(phase_q) == `STS_GATE_PH_LAST;
    endproperty
    a_end_aligned: assert property (p_end_aligned) else $error("Gate end off the boundary."); // R16

    c_seg_end: cover property (@(posedge mclk) disable iff (rst) seg_end);
endmodule // sts_gate_align

//--- sts_capture.sv
// Sample timestamp counter with mode register, trigger capture and timestamp queue.
// What this block does
// [R1] The counter steps up by one each sample clock while stamping is on.
// [R2] Each trigger event outside gated acquisition writes the present count into the separate timestamp queue.
// [R3] In gated acquisition both the start and the end of each segment are stamped.
// [R4] The queue is first-in first-out and can be drained while acquisition runs.
// [R5] The queue holds 64 K timestamps.
// [R6] A stamp is the number of samples since the last counter clear.
// [R7] Writing the zero command clears the counter.
// [R8] Writing the off code stops all stamping.
// [R9] The free-run code selects a mode cleared only by the zero command.
// [R10] In free-run mode the counter runs on across recordings with no automatic clear.
// [R11] The zero-on-start code selects stamps referenced to the acquisition start.
// [R12] In zero-on-start mode each acquisition start clears the counter.
// [R13] The command register takes commands and reads back the active mode.
// [R14] Stamping works with or without multiple recording and gated acquisition.
// [R15] In free-run mode the host issues the zero command after choosing the mode.
// [R16] A gate end is seen only on an eight-sample boundary, up to seven samples late.
// [R17] A full queue drops new stamps and keeps the stored ones.
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "sts_defines.svh"
module sts_capture (
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        rst,
    // Avalon-MM slave.
    input  wire logic [15:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Acquisition events.
    input  wire logic        acq_start,
    input  wire logic        trig_event,
    input  wire logic        gate_on,
    input  wire logic        gate_level
);
    sts_fifo_if f ();

    logic                         wait_q;
    logic [31:0]                  rdata_q;
    sts_pkg::sts_mode_t           mode_q;
    sts_pkg::sts_stamp_t          cnt_q;
    logic [`STS_PTR_W-1:0]        wr_ptr_q;
    logic [`STS_PTR_W-1:0]        rd_ptr_q;
    logic [`STS_FILL_W-1:0]       fill_q;
    logic                         acc;
    logic                         wr_acc;
    logic                         rd_acc;
    logic                         cmd_wr;
    logic                         clr_now;
    logic                         start_clr;
    logic                         seg_start;
    logic                         seg_end;
    logic                         event_now;
    logic                         push;
    logic                         pop;
    logic                         full;
    logic                         empty;

    sts_gate_align u_gate (
        .mclk       (mclk),
        .rst        (rst),
        .gate_on    (gate_on),
        .gate_level (gate_level),
        .seg_start  (seg_start),
        .seg_end    (seg_end)
    );

    sts_stamp_mem u_mem (
        .mclk (mclk),
        .f    (f.mem)
    );

    // Bus handshake: one wait cycle, then a single-cycle acknowledge.
    assign acc    = (avs_read | avs_write) & wait_q;
    assign wr_acc = avs_write & wait_q & (avs_byteenable == `STS_BE_ALL);
    assign rd_acc = avs_read & wait_q;
    assign cmd_wr = wr_acc & (avs_address == `STS_CMD_OFS); // R13

    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= ~acc;
        end
    end

    // Mode register: only valid mode codes change it.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mode_q <= sts_pkg::sts_off;
        end else if (cmd_wr) begin
            case (avs_writedata)
                `STS_OFF_CODE:   mode_q <= sts_pkg::sts_off; // R8
                `STS_FREE_CODE:  mode_q <= sts_pkg::sts_free; // R9
                `STS_START_CODE: mode_q <= sts_pkg::sts_start; // R11
                default:         mode_q <= mode_q;
            endcase
        end
    end

    // Counter clears and advance.
    assign clr_now   = cmd_wr & (avs_writedata == `STS_ZERO_CODE); // R7
    assign start_clr = (mode_q == sts_pkg::sts_start) & acq_start; // R12

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (clr_now || start_clr) begin
            cnt_q <= '0; // R6 R7 R12
        end else if (mode_q != sts_pkg::sts_off) begin
            cnt_q <= cnt_q + 48'h1; // R1 R10
        end
    end

    // Capture into the queue.
    assign full      = (fill_q == `STS_DEPTH);
    assign empty     = (fill_q == '0);
    assign event_now = gate_on ? (seg_start | seg_end) : trig_event; // R3 R14
    assign push      = (mode_q != sts_pkg::sts_off) & event_now & ~full; // R2 R8 R17
    assign pop       = rd_acc & (avs_address == `STS_DHI_OFS) & ~empty; // R4

    assign f.wr_en   = push;
    assign f.wr_addr = wr_ptr_q;
    assign f.wr_data = cnt_q; // R2 R6
    assign f.rd_addr = rd_ptr_q;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 16'h1; // R4 R5
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 16'h1; // R4
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fill_q <= '0;
        end else if (push && !pop) begin
            fill_q <= fill_q + 17'h1; // R5
        end else if (pop && !push) begin
            fill_q <= fill_q - 17'h1;
        end
    end

    // Read data, registered at the acknowledge.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_q <= 32'h0;
        end else if (rd_acc) begin
            case (avs_address)
                `STS_CMD_OFS: begin
                    case (mode_q)
                        sts_pkg::sts_free:  rdata_q <= `STS_FREE_CODE; // R13
                        sts_pkg::sts_start: rdata_q <= `STS_START_CODE; // R13
                        default:            rdata_q <= `STS_OFF_CODE; // R13
                    endcase
                end
                `STS_DLO_OFS: rdata_q <= empty ? 32'h0 : f.rd_data[31:0];
                `STS_DHI_OFS: rdata_q <= empty ? 32'h0 : {16'h0, f.rd_data[47:32]};
                `STS_STAT_OFS: rdata_q <= {full, empty, 13'h0, fill_q};
                default:      rdata_q <= 32'h0;
            endcase
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    property p_count_adv;
        (mode_q != sts_pkg::sts_off && !clr_now && !start_clr) |=> cnt_q == $past(cnt_q) + 48'h1;
    endproperty
    a_count_adv: assert property (p_count_adv) else $error("Counter did not advance."); // R1

    property p_store;
        (mode_q != sts_pkg::sts_off && !gate_on && trig_event && !full && !pop)
            |=> fill_q == $past(fill_q) + 17'h1;
    endproperty
    a_store: assert property (p_store) else $error("Trigger not stored."); // R2

    property p_gate_store;
        (mode_q != sts_pkg::sts_off && gate_on && (seg_start || seg_end) && !full && !pop)
            |=> fill_q == $past(fill_q) + 17'h1;
    endproperty
    a_gate_store: assert property (p_gate_store) else $error("Segment edge not stored."); // R3

    property p_pop;
        (pop && !push) |=> fill_q == $past(fill_q) - 17'h1 && rd_ptr_q == $past(rd_ptr_q) + 16'h1;
    endproperty
    a_pop: assert property (p_pop) else $error("Queue read did not drain."); // R4

    property p_depth;
        fill_q <= `STS_DEPTH && (full || wr_ptr_q - rd_ptr_q == fill_q[15:0]);
    endproperty
    a_depth: assert property (p_depth) else $error("Queue fill out of range."); // R5

    property p_clear;
        clr_now |=> cnt_q == 48'h0;
    endproperty
    a_clear: assert property (p_clear) else $error("Zero command missed."); // R7

    property p_off;
        (mode_q == sts_pkg::sts_off && !pop) |=> fill_q == $past(fill_q);
    endproperty
    a_off: assert property (p_off) else $error("Stamp stored while off."); // R8

    property p_start_zero;
        start_clr && !clr_now |=> cnt_q == 48'h0 ##1 (cnt_q == 48'h1 ||
            $past(mode_q) == sts_pkg::sts_off || $past(clr_now) || $past(start_clr));
    endproperty
    a_start_zero: assert property (p_start_zero) else $error("Start did not clear."); // R12

    property p_free_run;
        (mode_q == sts_pkg::sts_free && acq_start && !clr_now) |=> cnt_q != 48'h0 || $past(cnt_q) == '1;
    endproperty
    a_free_run: assert property (p_free_run) else $error("Free run cleared at start."); // R10

    property p_mode_read;
        (rd_acc && avs_address == `STS_CMD_OFS && mode_q == sts_pkg::sts_start)
            |=> !avs_waitrequest && avs_readdata == `STS_START_CODE;
    endproperty
    a_mode_read: assert property (p_mode_read) else $error("Mode read back wrong."); // R13

    property p_full_keep;
        (full && event_now && !pop) |=> fill_q == `STS_DEPTH && wr_ptr_q == $past(wr_ptr_q);
    endproperty
    a_full_keep: assert property (p_full_keep) else $error("Full queue overwritten."); // R17

    property p_ack_one;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("Request not acknowledged."); // R13

    property p_ack_short;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_ack_short: assert property (p_ack_short) else $error("Acknowledge held too long."); // R13

    property p_read_free;
        (rd_acc && avs_address == `STS_CMD_OFS && mode_q == sts_pkg::sts_free)
            |=> avs_readdata == `STS_FREE_CODE;
    endproperty
    a_read_free: assert property (p_read_free) else $error("Free-run mode read back wrong."); // R9

    property p_read_off;
        (rd_acc && avs_address == `STS_CMD_OFS && mode_q == sts_pkg::sts_off)
            |=> avs_readdata == `STS_OFF_CODE;
    endproperty
    a_read_off: assert property (p_read_off) else $error("Off mode read back wrong."); // R8

    property p_bad_code;
        (cmd_wr && !(avs_writedata inside {`STS_OFF_CODE, `STS_START_CODE, `STS_FREE_CODE}))
            |=> mode_q == $past(mode_q);
    endproperty
    a_bad_code: assert property (p_bad_code) else $error("Unknown code changed the mode."); // R13

    property p_part_write;
        (avs_write && avs_byteenable != `STS_BE_ALL) |=> mode_q == $past(mode_q);
    endproperty
    a_part_write: assert property (p_part_write) else $error("Partial write changed the mode."); // R13

    property p_off_hold;
        (mode_q == sts_pkg::sts_off && !clr_now) |=> cnt_q == $past(cnt_q);
    endproperty
    a_off_hold: assert property (p_off_hold) else $error("Counter ran while off."); // R8

    property p_empty_read;
        (rd_acc && avs_address == `STS_DLO_OFS && empty) |=> avs_readdata == 32'h0;
    endproperty
    a_empty_read: assert property (p_empty_read) else $error("Empty queue read not zero."); // R4

    property p_empty_hold;
        (empty && !push) |=> empty;
    endproperty
    a_empty_hold: assert property (p_empty_hold) else $error("Empty queue drained further."); // R4

    property p_stat_read;
        (rd_acc && avs_address == `STS_STAT_OFS)
            |=> avs_readdata[`STS_STAT_FULL] == $past(full)
            && avs_readdata[`STS_STAT_EMPTY] == $past(empty)
            && avs_readdata[16:0] == $past(fill_q);
    endproperty
    a_stat_read: assert property (p_stat_read) else $error("Status read back wrong."); // R5

    property p_push_ptr;
        push |=> wr_ptr_q == $past(wr_ptr_q) + 16'h1;
    endproperty
    a_push_ptr: assert property (p_push_ptr) else $error("Write pointer did not step."); // R4

    property p_read_hold;
        !rd_acc |=> avs_readdata == $past(avs_readdata);
    endproperty
    a_read_hold: assert property (p_read_hold) else $error("Read data changed without a read."); // R13

    c_store: cover property (push);
    c_full:  cover property (full);
    c_pop:   cover property (pop);
    c_clear: cover property (clr_now ##[1:20] push);
endmodule // sts_capture

//--- sample_timestamp_capture_test.sv
// Self-checking testbench of the sample timestamp capture block.
`timescale 1ns/1ns
`include "sts_defines.svh"
module sample_timestamp_capture_test;
    logic                mclk            = 1'b0;
    logic                rst             = 1'b1;
    logic [15:0]         avs_address     = 16'h0000;
    logic                avs_read        = 1'b0;
    logic                avs_write       = 1'b0;
    logic [31:0]         avs_writedata   = 32'h0000_0000;
    logic [3:0]          avs_byteenable  = 4'hf;
    logic [31:0]         avs_readdata;
    logic                avs_waitrequest;
    logic                acq_start       = 1'b0;
    logic                trig_event      = 1'b0;
    logic                gate_on         = 1'b0;
    logic                gate_level      = 1'b0;
    int                  errors          = 0;
    int                  num_checks      = 0;
    integer              seed            = 32'hc2144bfb;
    logic [31:0]         m_mode          = `STS_OFF_CODE;
    logic [47:0]         exp_cnt         = 48'h0;
    sts_pkg::sts_stamp_t exp_q[$];
    sts_pkg::sts_stamp_t s;
    logic [47:0]         c0;
    logic [47:0]         c1;
    logic [31:0]         v;
    int                  n;

    always #50 mclk = ~mclk;

    sts_capture u_sts_capture (
        .mclk            (mclk),
        .rst             (rst),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .acq_start       (acq_start),
        .trig_event      (trig_event),
        .gate_on         (gate_on),
        .gate_level      (gate_level)
    );

    task automatic wrap_up();
        if (errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input logic [47:0] got, input logic [47:0] lo, input logic [47:0] hi);
        num_checks++;
        if (((got >= lo) && (got <= hi)) !== 1'b1) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, lo);
        end
    endtask

    task automatic step();
        @(posedge mclk);
        if (m_mode !== `STS_OFF_CODE) exp_cnt = exp_cnt + 48'h1;
    endtask

    task automatic tick(input int k);
        repeat (k) step();
    endtask

    task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] rd);
        int i;
        avs_address    <= a;
        avs_write      <= wr;
        avs_read       <= ~wr;
        avs_writedata  <= d;
        avs_byteenable <= be;
        for (i = 0; i < 100; i++) begin
            step();
            if (i == 0 && wr && be == `STS_BE_ALL) begin
                if (d == `STS_ZERO_CODE) exp_cnt = 48'h0;
                else if (d inside {`STS_OFF_CODE, `STS_START_CODE, `STS_FREE_CODE}) m_mode = d;
            end
            if (avs_waitrequest === 1'b0) break;
        end
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (i == 100) begin
            errors++;
            wrap_up();
        end
        step();
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, `STS_BE_ALL, x);
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, `STS_BE_ALL, x);
        chk({32'h0, x}, {32'h0, exp});
    endtask

    task automatic stat_chk(input logic f, input logic e, input logic [16:0] cnt);
        logic [31:0] x;
        bus(1'b0, `STS_STAT_OFS, 32'h0, `STS_BE_ALL, x);
        chk({45'h0, x[31], x[30], x[16:0]}, {45'h0, f, e, cnt});
    endtask

    task automatic pop_raw(output sts_pkg::sts_stamp_t st);
        logic [31:0] lo;
        logic [31:0] hi;
        bus(1'b0, `STS_DLO_OFS, 32'h0, `STS_BE_ALL, lo);
        bus(1'b0, `STS_DHI_OFS, 32'h0, `STS_BE_ALL, hi);
        st = {hi[15:0], lo};
    endtask

    task automatic pop_chk();
        sts_pkg::sts_stamp_t st;
        pop_raw(st);
        chk({16'h0, st}, {16'h0, exp_q.pop_front()});
    endtask

    task automatic pulse_trig(input logic store);
        if (store) exp_q.push_back(exp_cnt);
        trig_event <= 1'b1;
        step();
        trig_event <= 1'b0;
        step();
    endtask

    task automatic acq();
        acq_start <= 1'b1;
        step();
        if (m_mode == `STS_START_CODE) exp_cnt = 48'h0;
        acq_start <= 1'b0;
        step();
    endtask

    initial begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        step();
        rd_chk(`STS_CMD_OFS, `STS_OFF_CODE);
        stat_chk(1'b0, 1'b1, 17'h0);
        rd_chk(`STS_DLO_OFS, 32'h0);
        rd_chk(`STS_DHI_OFS, 32'h0);
        stat_chk(1'b0, 1'b1, 17'h0);
        rd_chk(16'h0010, 32'h0);
        bus(1'b1, `STS_CMD_OFS, `STS_FREE_CODE, 4'h3, v);
        rd_chk(`STS_CMD_OFS, `STS_OFF_CODE);
        repeat (3) pulse_trig(1'b0);
        tick(3);
        stat_chk(1'b0, 1'b1, 17'h0);
        wr(`STS_CMD_OFS, `STS_START_CODE);
        rd_chk(`STS_CMD_OFS, `STS_START_CODE);
        wr(`STS_CMD_OFS, 32'h0000_0005);
        rd_chk(`STS_CMD_OFS, `STS_START_CODE);
        for (n = 0; n < 3; n++) begin
            acq();
            tick(($random(seed) & 32'hf) + 1);
            pulse_trig(1'b1);
            pulse_trig(1'b1);
        end
        tick(3);
        stat_chk(1'b0, 1'b0, 17'h6);
        repeat (6) pop_chk();
        wr(`STS_CMD_OFS, `STS_FREE_CODE);
        wr(`STS_CMD_OFS, `STS_ZERO_CODE);
        rd_chk(`STS_CMD_OFS, `STS_FREE_CODE);
        for (n = 0; n < 3; n++) begin
            tick(($random(seed) & 32'h1f) + 1);
            pulse_trig(1'b1);
            acq();
            pop_chk();
        end
        gate_on <= 1'b1;
        tick(4);
        gate_level <= 1'b1;
        c0 = exp_cnt;
        tick(12 + ($random(seed) & 32'h7));
        gate_level <= 1'b0;
        c1 = exp_cnt;
        tick(12);
        gate_on <= 1'b0;
        stat_chk(1'b0, 1'b0, 17'h2);
        pop_raw(s);
        chk_rng(s, c0, c0 + 48'h2);
        pop_raw(s);
        chk_rng(s, c1, c1 + 48'h9);
        wr(`STS_CMD_OFS, `STS_ZERO_CODE);
        trig_event <= 1'b1;
        for (n = 0; n < 65540; n++) begin
            if (exp_q.size() < 65536) exp_q.push_back(exp_cnt);
            step();
        end
        trig_event <= 1'b0;
        tick(3);
        stat_chk(1'b1, 1'b0, `STS_DEPTH);
        pop_chk();
        pop_chk();
        stat_chk(1'b0, 1'b0, `STS_DEPTH - 17'h2);
        wrap_up();
    end
endmodule // sample_timestamp_capture_test
